/* File: design/port_pkg.sv */
package port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes and phases
  localparam int          PORT_WIDTH      = 8;
  localparam int          BIT_SEL_WIDTH   = 3;
  localparam int          PHASES_PER_INSN = 4;
  localparam logic [1:0]  PHASE_FIRST     = 2'h0;
  localparam logic [1:0]  PHASE_LAST      = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and pin options
  localparam logic [7:0]  LATCH_RESET     = 8'h00;
  localparam logic [7:0]  READ_RESET      = 8'h00;
  localparam logic [7:0]  OE_N_RESET      = 8'hff;
  localparam logic [7:0]  PIN_OUT_RESET   = 8'h00;
  // Pins whose driver may only pull low
  localparam logic [7:0]  OPEN_DRAIN_MASK = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Port operations carried by one instruction cycle
  typedef enum logic [2:0] {
    OP_NONE,
    OP_READ,
    OP_WRITE,
    OP_BIT_SET,
    OP_BIT_CLEAR
  } port_op_type;

  typedef struct packed {
    port_op_type              op;
    logic [BIT_SEL_WIDTH-1:0] bitSel;
    logic [PORT_WIDTH-1:0]    wrData;
  } port_req_type;

endpackage : port_pkg

/* File: design/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Asynchronous pin levels in, settled levels out
  input  wire logic [7:0] asyncIn,
  output logic      [7:0] syncOut
);
  import port_pkg::*;

  logic [PORT_WIDTH-1:0] stage1_r;
  logic [PORT_WIDTH-1:0] stage2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops per pin; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < PORT_WIDTH; i = i + 1)
    begin : gSync
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          stage1_r[i] <= 1'b0;
          stage2_r[i] <= 1'b0;
        end
        else
        begin
          stage1_r[i] <= asyncIn[i];
          stage2_r[i] <= stage1_r[i];
        end
      end
    end
  endgenerate

  assign syncOut = stage2_r;

endmodule : pin_sync

/* File: design/bidir_port_latch_rmw.sv */
`timescale 1ns/1ns
module bidir_port_latch_rmw
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Core side
  input  wire port_pkg::port_req_type req,
  input  wire logic [7:0]            direction,
  output logic                       cycleStart_r,
  output logic [7:0]                 readData_r,
  output logic [7:0]                 latchValue_r,
  // Pin side
  input  wire logic [7:0]            pinIn,
  output logic [7:0]                 pinOut_r,
  output logic [7:0]                 pinOe_n_r
);
  import port_pkg::*;

  logic [1:0]             phase_r;
  logic [1:0]             phase_nxt;
  logic                   cycleStart_nxt;
  port_op_type            op_r;
  port_op_type            op_nxt;
  logic [BIT_SEL_WIDTH-1:0] bitSel_r;
  logic [BIT_SEL_WIDTH-1:0] bitSel_nxt;
  logic [PORT_WIDTH-1:0]  wrData_r;
  logic [PORT_WIDTH-1:0]  wrData_nxt;
  logic [PORT_WIDTH-1:0]  readData_nxt;
  logic [PORT_WIDTH-1:0]  latch_nxt;
  logic [PORT_WIDTH-1:0]  pinOut_nxt;
  logic [PORT_WIDTH-1:0]  pinOe_n_nxt;
  logic [PORT_WIDTH-1:0]  pinLevel;
  logic [PORT_WIDTH-1:0]  bitMask;

  ////////////////////////////////////////////////////////////////////////////
  // Pin levels pass two flops before use
  pin_sync uSync
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn (pinIn),
    .syncOut (pinLevel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle phases: request taken and pins sampled in phase 0
  always_comb
  begin
    phase_nxt      = phase_r + 2'h1;
    cycleStart_nxt = (phase_nxt == PHASE_FIRST);
    op_nxt         = op_r;
    bitSel_nxt     = bitSel_r;
    wrData_nxt     = wrData_r;
    readData_nxt   = readData_r;
    if (phase_r == PHASE_FIRST)
    begin
      op_nxt       = req.op;
      bitSel_nxt   = req.bitSel;
      wrData_nxt   = req.wrData;
      // Sampled at the start, so a write just before is not seen yet
      readData_nxt = pinLevel;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      phase_r      <= PHASE_FIRST;
      cycleStart_r <= 1'b0;
      op_r         <= OP_NONE;
      bitSel_r     <= '0;
      wrData_r     <= '0;
      readData_r   <= READ_RESET;
    end
    else
    begin
      phase_r      <= phase_nxt;
      cycleStart_r <= cycleStart_nxt;
      op_r         <= op_nxt;
      bitSel_r     <= bitSel_nxt;
      wrData_r     <= wrData_nxt;
      readData_r   <= readData_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch update at the last phase
  // Bit ops modify the sampled pins, not the latch, so input pins
  // pick up whatever level they carry; software must live with that.
  assign bitMask = PORT_WIDTH'(1) << bitSel_r;

  always_comb
  begin
    latch_nxt = latchValue_r;
    if (phase_r == PHASE_LAST)
    begin
      case (op_r)
        OP_WRITE:     latch_nxt = wrData_r;
        OP_BIT_SET:   latch_nxt = readData_r | bitMask;
        OP_BIT_CLEAR: latch_nxt = readData_r & ~bitMask;
        default:      latch_nxt = latchValue_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers follow latch and direction (1 = input)
  // Latch is never cleared on a direction change, so old content shows.
  always_comb
  begin
    pinOut_nxt  = latch_nxt & ~OPEN_DRAIN_MASK;
    pinOe_n_nxt = direction;
    // Open drain pins only enable the driver to pull low
    pinOe_n_nxt = pinOe_n_nxt | (OPEN_DRAIN_MASK & latch_nxt);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      latchValue_r <= LATCH_RESET;
      pinOut_r     <= PIN_OUT_RESET;
      pinOe_n_r    <= OE_N_RESET;
    end
    else
    begin
      latchValue_r <= latch_nxt;
      pinOut_r     <= pinOut_nxt;
      pinOe_n_r    <= pinOe_n_nxt;
    end
  end

endmodule : bidir_port_latch_rmw

/* File: test/port_checker.sv */
`timescale 1ns/1ns
module port_checker
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // Core side
  input wire port_pkg::port_req_type req,
  input wire logic [7:0]             direction,
  input wire logic                   cycleStart_r,
  input wire logic [7:0]             readData_r,
  input wire logic [7:0]             latchValue_r,
  // Pin side
  input wire logic [7:0]             pinOut_r,
  input wire logic [7:0]             pinOe_n_r
);
  import port_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycle framing: sample at start, latch at end
  a_start_period: assert property (cycleStart_r |=> !cycleStart_r [*3] ##1 cycleStart_r)
    else $error("period");
  a_latch_at_end: assert property ($changed(latchValue_r) |-> cycleStart_r)
    else $error("latch moment");
  a_read_at_start: assert property ($changed(readData_r) |->
    $past(cycleStart_r) || !$past(rst_n, 2)) else $error("read moment");
  // Drivers only where direction asks; first cycle after reset is skipped
  a_oe_follow: assert property ($past(rst_n) |->
    ((pinOe_n_r ^ $past(direction)) & ~OPEN_DRAIN_MASK) == 8'h00) else $error("oe");
  a_od_low: assert property (!pinOe_n_r[4] |-> !latchValue_r[4] && !pinOut_r[4])
    else $error("open drain");
  a_drive_latch: assert property (((pinOut_r ^ latchValue_r) & ~pinOe_n_r) == 8'h00)
    else $error("drive");
  // Whole byte written back three edges after the take, checked on the fourth
  a_write_latch: assert property (req.op == OP_WRITE && cycleStart_r |->
    ##4 latchValue_r == $past(req.wrData, 4)) else $error("write");
  a_set_rmw: assert property (req.op == OP_BIT_SET && cycleStart_r |->
    ##4 latchValue_r == ($past(readData_r, 3) | (8'h01 << $past(req.bitSel, 4))))
    else $error("bit set");
  a_clear_rmw: assert property (req.op == OP_BIT_CLEAR && cycleStart_r |->
    ##4 latchValue_r == ($past(readData_r, 3) & ~(8'h01 << $past(req.bitSel, 4))))
    else $error("bit clear");
  c_write: cover property (req.op == OP_WRITE && cycleStart_r);
  c_set: cover property (req.op == OP_BIT_SET && cycleStart_r);
  c_clear: cover property (req.op == OP_BIT_CLEAR && cycleStart_r);
endmodule : port_checker

/* File: test/pin_partner.sv */
`timescale 1ns/1ns
module pin_partner
(
  // Device drive and outside level
  input  wire logic [7:0] pinOut_r,
  input  wire logic [7:0] pinOe_n_r,
  input  wire logic [7:0] extLevel,
  output logic      [7:0] pinLevel
);
  // Outside circuitry yields wherever the device drives
  assign pinLevel = (pinOut_r & ~pinOe_n_r) | (extLevel & pinOe_n_r);
endmodule : pin_partner

/* File: test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import port_pkg::*;
  logic clk, rst_n, cycleStart_r;
  port_req_type req;
  port_op_type o;
  logic [2:0] b;
  logic [7:0] direction, extLevel, pins, readData_r, latchValue_r, pinOut_r, pinOe_n_r, d, p, e;
  int n_mismatch, checks_done, seed;
  bidir_port_latch_rmw uut (.clk(clk), .rst_n(rst_n), .req(req), .direction(direction),
    .cycleStart_r(cycleStart_r), .readData_r(readData_r), .latchValue_r(latchValue_r),
    .pinIn(pins), .pinOut_r(pinOut_r), .pinOe_n_r(pinOe_n_r));
  pin_partner far (.pinOut_r(pinOut_r), .pinOe_n_r(pinOe_n_r), .extLevel(extLevel),
    .pinLevel(pins));
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Hold request through the phase-0 clock, bounded wait
  task automatic op(input port_op_type t, input logic [2:0] s, input logic [7:0] w);
    int i;
    i = 0;
    do @(posedge clk) #1 i++; while (cycleStart_r !== 1'b1 && i < 9);
    check("start", 8'(cycleStart_r), 8'h01);
    req = '{t, s, w};
    @(posedge clk) #1 req.op = OP_NONE;
  endtask : op
  // Pin level: open drain bit only pulls low
  function automatic logic [7:0] pinsExp(input logic [7:0] dir, lat, ext);
    logic [7:0] drv;
    drv = ~dir & ~(lat & OPEN_DRAIN_MASK);
    return (lat & drv) | (ext & ~drv);
  endfunction : pinsExp
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Watchdog well past the expected run length
  initial
  begin
    #100000;
    n_mismatch++;
    final_report();
  end
  initial
  begin
    seed = 32'h42f9;
    req = '{OP_NONE, 3'h0, 8'h00};
    direction = 8'hff;
    extLevel = 8'h00;
    e = LATCH_RESET;
    rst_n = 0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    check("rst oe", pinOe_n_r, OE_N_RESET);
    check("rst latch", latchValue_r, LATCH_RESET);
    check("rst out", pinOut_r, PIN_OUT_RESET);
    check("rst read", readData_r, READ_RESET);
    // All outputs, all inputs, then random mixes
    for (int k = 0; k < 48; k++)
    begin
      direction = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
      extLevel = 8'($random(seed));
      op(OP_NONE, 3'h0, 8'h00);
      p = pinsExp(direction, e, extLevel);
      o = port_op_type'(1 + k % 4);
      b = 3'($random(seed));
      d = 8'($random(seed));
      op(o, b, d);
      check("read", readData_r, p);
      repeat (3) @(posedge clk);
      #1 e = (o == OP_WRITE) ? d : (o == OP_BIT_SET) ? p | (8'h01 << b) :
        (o == OP_BIT_CLEAR) ? p & ~(8'h01 << b) : e;
      check("latch", latchValue_r, e);
      check("oe", pinOe_n_r, direction | (e & OPEN_DRAIN_MASK));
      check("out", pinOut_r, e & ~OPEN_DRAIN_MASK);
    end
    final_report();
  end
endmodule : tb_top
bind bidir_port_latch_rmw port_checker chk (.clk(clk), .rst_n(rst_n), .req(req),
  .direction(direction), .cycleStart_r(cycleStart_r), .readData_r(readData_r),
  .latchValue_r(latchValue_r), .pinOut_r(pinOut_r), .pinOe_n_r(pinOe_n_r));
